// File: hdl/hant_hop_if.sv
`timescale 1ns/1ns
// Hop tracker outputs toward the timing core
interface hant_hop_if;
    logic hop_pulse;
    logic hop_predict;
    logic hop_seen;

    modport tracker (output hop_pulse, output hop_predict, output hop_seen);
    modport core (input hop_pulse, input hop_predict, input hop_seen);
endinterface : hant_hop_if

// File: hdl/hant_hop_track.sv
`timescale 1ns/1ns
// Detects hops on the radio hop-sync line and predicts the next one.
module hant_hop_track #(
    parameter int CW = 32
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic hop_sync_i,
    input wire logic dwell_known_i,
    input wire logic [CW-1:0] hop_period_i,
    input wire logic [CW-1:0] slot_i,
    hant_hop_if.tracker hop
);
    logic sync_d_ff, nxt_sync_d;
    logic seen_ff, nxt_seen;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic edge_w;
    logic [CW-1:0] span_w;

    // ------------------------------------------------------------
    // Edge detect and prediction counter
    // ------------------------------------------------------------
    assign edge_w = hop_sync_i & ~sync_d_ff;
    // Without hop timing, every slot is treated as a hop
    assign span_w = (dwell_known_i && seen_ff) ? hop_period_i
                                               : slot_i;

    always_comb begin
        nxt_sync_d = hop_sync_i;
        nxt_seen = seen_ff | edge_w;
        nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
        // Real hop re-aligns the prediction, so drift never builds up
        if (edge_w || cnt_ff >= span_w - {{(CW-1){1'b0}}, 1'b1}) begin
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_d_ff <= 1'b0;
            seen_ff <= 1'b0;
            cnt_ff <= '0;
        end else begin
            sync_d_ff <= nxt_sync_d;
            seen_ff <= nxt_seen;
            cnt_ff <= nxt_cnt;
        end
    end

    assign hop.hop_pulse = edge_w;
    assign hop.hop_predict = (cnt_ff == span_w - {{(CW-1){1'b0}}, 1'b1});
    assign hop.hop_seen = seen_ff;
endmodule : hant_hop_track

// File: hdl/hant_pkg.sv
package hant_pkg;

    // ------------------------------------------------------------
    // Register map (word addresses on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LONG_DWELL = 4'h1;
    localparam logic [3:0] ADDR_HOP_PERIOD = 4'h2;
    localparam logic [3:0] ADDR_SLOT = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_LAST_BIT_TS = 4'h5;
    localparam logic [3:0] ADDR_FLAG_TS = 4'h6;
    localparam logic [3:0] ADDR_HOLD_S = 4'h7;
    localparam logic [3:0] ADDR_TIME = 4'h8;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTRL_DWELL_KNOWN = 0;
    localparam int CTRL_FEC = 1;
    localparam int CTRL_DISP = 2;
    localparam int CTRL_TX_REQ = 3;

    // ------------------------------------------------------------
    // Reset values and timing constants
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] LONG_DWELL_RST = 32'h0000_0000;
    localparam logic [31:0] HOP_PERIOD_RST = 32'h0000_4E20;
    localparam logic [31:0] SLOT_RST = 32'h0000_0100;
    localparam logic [31:0] BASE_S_RST = 32'h0000_0400;
    localparam logic [31:0] ACK_T3_S_ADD = 32'h0000_0800;
    localparam logic [1:0] ACK_SINGLE = 2'h0;
    localparam logic [1:0] ACK_MULTI_T3 = 2'h3;

endpackage : hant_pkg

// File: hdl/hant_timing.sv
`timescale 1ns/1ns
module hant_timing #(
    parameter int CW = 32
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic hop_sync_i,
    input wire logic rx_multi_dwell_i,
    input wire logic rx_last_bit_i,
    input wire logic rx_final_flag_i,
    output logic tx_start_o,
    output logic ack_multi_dwell_o,
    output logic fec_en_o,
    output logic disp_en_o
);
    typedef enum {ST_IDLE, ST_WAIT_LONG, ST_WAIT_NEXT} hant_tx_st_t;

    hant_hop_if hop_bus ();

    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] long_dwell_ff, nxt_long_dwell;
    logic [31:0] hop_period_ff, nxt_hop_period;
    logic [31:0] slot_ff, nxt_slot;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [CW-1:0] time_ff, nxt_time;
    logic [CW-1:0] last_ts_ff, nxt_last_ts;
    logic [CW-1:0] flag_ts_ff, nxt_flag_ts;
    logic last_md_ff, nxt_last_md;
    logic ts_new_ff, nxt_ts_new;
    hant_tx_st_t st_ff, nxt_st;
    logic tx_start_ff, nxt_tx_start;
    logic ack_md_ff, nxt_ack_md;
    logic fec_ff, nxt_fec;
    logic disp_ff, nxt_disp;
    logic hop_w;
    logic long_ok_w;
    logic [31:0] hold_s_w;

    // Widen a counter value into the 32-bit read path
    function automatic logic [31:0] hant_w32(input logic [CW-1:0] v);
        hant_w32 = 32'(v);
    endfunction : hant_w32

    // ------------------------------------------------------------
    // Hop tracking
    // ------------------------------------------------------------
    hant_hop_track #(.CW(CW)) u_hop (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .hop_sync_i(hop_sync_i),
        .dwell_known_i(ctrl_ff[hant_pkg::CTRL_DWELL_KNOWN]),
        .hop_period_i(CW'(hop_period_ff)),
        .slot_i(CW'(slot_ff)),
        .hop(hop_bus.tracker)
    );

    // A hop is taken as the detected edge or the predicted boundary
    assign hop_w = hop_bus.hop_pulse | hop_bus.hop_predict;

    // A long dwell only counts when configured and dwell length is known
    assign long_ok_w = (long_dwell_ff != 32'h0000_0000) &&
                       ctrl_ff[hant_pkg::CTRL_DWELL_KNOWN];

    // Inflated S term; fixed type 3 ack at worst hop rate when multi-dwell
    assign hold_s_w = ack_md_ff ? hant_pkg::BASE_S_RST + hant_pkg::ACK_T3_S_ADD
                                : hant_pkg::BASE_S_RST;

    // ------------------------------------------------------------
    // Register file next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_long_dwell = long_dwell_ff;
        nxt_hop_period = hop_period_ff;
        nxt_slot = slot_ff;
        nxt_rdata = 32'h0000_0000;
        if (reg_wr_i) begin
            case (reg_addr_i)
                hant_pkg::ADDR_CTRL: nxt_ctrl = reg_wdata_i;
                hant_pkg::ADDR_LONG_DWELL: nxt_long_dwell = reg_wdata_i;
                hant_pkg::ADDR_HOP_PERIOD: nxt_hop_period = reg_wdata_i;
                hant_pkg::ADDR_SLOT: nxt_slot = reg_wdata_i;
                default: ;
            endcase
        end
        // Start request is a self-clearing bit
        if (st_ff != ST_IDLE) begin
            nxt_ctrl[hant_pkg::CTRL_TX_REQ] = 1'b0;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                hant_pkg::ADDR_CTRL: nxt_rdata = ctrl_ff;
                hant_pkg::ADDR_LONG_DWELL: nxt_rdata = long_dwell_ff;
                hant_pkg::ADDR_HOP_PERIOD: nxt_rdata = hop_period_ff;
                hant_pkg::ADDR_SLOT: nxt_rdata = slot_ff;
                hant_pkg::ADDR_STATUS:
                    nxt_rdata = {26'h0, ts_new_ff, last_md_ff,
                                 hop_bus.hop_seen, st_ff == ST_IDLE,
                                 ack_md_ff, long_ok_w};
                hant_pkg::ADDR_LAST_BIT_TS: nxt_rdata = hant_w32(last_ts_ff);
                hant_pkg::ADDR_FLAG_TS: nxt_rdata = hant_w32(flag_ts_ff);
                hant_pkg::ADDR_HOLD_S: nxt_rdata = hold_s_w;
                hant_pkg::ADDR_TIME: nxt_rdata = hant_w32(time_ff);
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_ff <= hant_pkg::CTRL_RST;
            long_dwell_ff <= hant_pkg::LONG_DWELL_RST;
            hop_period_ff <= hant_pkg::HOP_PERIOD_RST;
            slot_ff <= hant_pkg::SLOT_RST;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            long_dwell_ff <= nxt_long_dwell;
            hop_period_ff <= nxt_hop_period;
            slot_ff <= nxt_slot;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Receive timestamps
    // ------------------------------------------------------------
    always_comb begin
        nxt_time = time_ff + {{(CW-1){1'b0}}, 1'b1};
        nxt_last_ts = last_ts_ff;
        nxt_flag_ts = flag_ts_ff;
        nxt_last_md = last_md_ff;
        nxt_ts_new = ts_new_ff;
        // Reading the last-bit stamp clears the fresh flag; capture wins
        if (reg_rd_i && reg_addr_i == hant_pkg::ADDR_LAST_BIT_TS) begin
            nxt_ts_new = 1'b0;
        end
        // Rate of multi-dwell data is unknown, so stamp the bit itself
        if (rx_last_bit_i) begin
            nxt_last_ts = time_ff;
            nxt_last_md = rx_multi_dwell_i;
            nxt_ts_new = 1'b1;
        end
        if (rx_final_flag_i) begin
            nxt_flag_ts = time_ff;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            time_ff <= '0;
            last_ts_ff <= '0;
            flag_ts_ff <= '0;
            last_md_ff <= 1'b0;
            ts_new_ff <= 1'b0;
        end else begin
            time_ff <= nxt_time;
            last_ts_ff <= nxt_last_ts;
            flag_ts_ff <= nxt_flag_ts;
            last_md_ff <= nxt_last_md;
            ts_new_ff <= nxt_ts_new;
        end
    end

    // ------------------------------------------------------------
    // Transmit start sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_tx_start = 1'b0;
        nxt_ack_md = ~long_ok_w;
        nxt_fec = ctrl_ff[hant_pkg::CTRL_FEC];
        nxt_disp = ctrl_ff[hant_pkg::CTRL_DISP];
        case (st_ff)
            ST_IDLE: begin
                if (ctrl_ff[hant_pkg::CTRL_TX_REQ]) begin
                    nxt_st = ST_WAIT_LONG;
                end
            end
            // First hop opens the guaranteed long dwell
            ST_WAIT_LONG: begin
                if (hop_w) begin
                    nxt_st = ST_WAIT_NEXT;
                end
            end
            // Crypto sync is imprecise, so skip to the following dwell
            ST_WAIT_NEXT: begin
                if (hop_w) begin
                    nxt_tx_start = 1'b1;
                    nxt_st = ST_IDLE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= ST_IDLE;
            tx_start_ff <= 1'b0;
            ack_md_ff <= 1'b1;
            fec_ff <= 1'b0;
            disp_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            tx_start_ff <= nxt_tx_start;
            ack_md_ff <= nxt_ack_md;
            fec_ff <= nxt_fec;
            disp_ff <= nxt_disp;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign tx_start_o = tx_start_ff;
    assign ack_multi_dwell_o = ack_md_ff;
    assign fec_en_o = fec_ff;
    assign disp_en_o = disp_ff;
endmodule : hant_timing

// File: verif/hant_radio_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------
// Radio model: hop-sync line of a hopping radio
// ----------------------------------------------------------
module hant_radio_model (
    input wire logic core_clk_i,
    input wire logic en_i,
    input wire logic [15:0] period_i,
    output logic hop_sync_o
);
    logic [15:0] cnt_ff;

    // Dwell counter; a silent radio rests the line low, never stale
    always_ff @(posedge core_clk_i) begin
        if (!en_i || cnt_ff >= period_i - 16'h1) begin
            cnt_ff <= 16'h0;
        end else begin
            cnt_ff <= cnt_ff + 16'h1;
        end
    end
    // Marker high for four cycles at the start of each dwell
    assign hop_sync_o = en_i && cnt_ff < 16'h4;
endmodule : hant_radio_model

// File: verif/hant_timing_asserts.sv
`timescale 1ns/1ns
// ----------------------------------------------------------
// Port checker for the hop-aligned timing block
// ----------------------------------------------------------
module hant_timing_asserts (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic rx_multi_dwell_i,
    input wire logic rx_last_bit_i,
    input wire logic tx_start_o,
    input wire logic ack_multi_dwell_o,
    input wire logic fec_en_o,
    input wire logic disp_en_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Bus steps; config outputs are judged two edges on, read data one edge on
    sequence s_ctrl_wr;
        reg_wr_i && reg_addr_i == hant_pkg::ADDR_CTRL;
    endsequence
    sequence s_rd(logic [3:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    sequence s_bit_then_stat;
        rx_last_bit_i ##1 s_rd(hant_pkg::ADDR_STATUS);
    endsequence

    chk_fec_disp_cfg: assert property (s_ctrl_wr |-> ##2
        fec_en_o == $past(reg_wdata_i[hant_pkg::CTRL_FEC], 2) &&
        disp_en_o == $past(reg_wdata_i[hant_pkg::CTRL_DISP], 2))
        else $error("coding enables do not follow control");
    chk_unknown_multi: assert property (s_ctrl_wr ##0
        !reg_wdata_i[0] |-> ##2 ack_multi_dwell_o)
        else $error("unknown dwell did not force multi ack");
    chk_short_dwell: assert property (reg_wr_i &&
        reg_addr_i == hant_pkg::ADDR_LONG_DWELL && reg_wdata_i == 32'h0
        |-> ##2 ack_multi_dwell_o)
        else $error("no long dwell but single ack");
    chk_tx_pulse: assert property (tx_start_o |=> !tx_start_o)
        else $error("transmit start longer than one cycle");
    chk_hold_inflate: assert property (s_rd(hant_pkg::ADDR_HOLD_S) |=>
        reg_rdata_o == ($past(ack_multi_dwell_o) ? 32'h0000_0C00 :
        32'h0000_0400))
        else $error("hold delay S term wrong");
    chk_ack_status: assert property (s_rd(hant_pkg::ADDR_STATUS) |=>
        reg_rdata_o[1] == $past(ack_multi_dwell_o))
        else $error("status ack method differs from output");
    chk_ts_new_set: assert property (s_bit_then_stat |=> reg_rdata_o[5])
        else $error("last bit not flagged as new timestamp");
    chk_md_status: assert property ((rx_multi_dwell_i and
        s_bit_then_stat) |=> reg_rdata_o[4])
        else $error("multi-dwell arrival not flagged");
endmodule : hant_timing_asserts

bind hant_timing hant_timing_asserts u_chk (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rx_multi_dwell_i(rx_multi_dwell_i),
    .rx_last_bit_i(rx_last_bit_i), .tx_start_o(tx_start_o),
    .ack_multi_dwell_o(ack_multi_dwell_o), .fec_en_o(fec_en_o),
    .disp_en_o(disp_en_o));

// File: verif/test_hant_timing.sv
`timescale 1ns/1ns
module test_hant_timing;
    logic core_clk_i = 1'b0;
    logic reset_n_i, reg_wr_i, reg_rd_i, hop_sync, radio_en;
    logic rx_multi_dwell_i, rx_last_bit_i, rx_final_flag_i;
    logic tx_start_o, ack_multi_dwell_o, fec_en_o, disp_en_o;
    logic [3:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, v, t0;
    logic [15:0] radio_period;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int hops = 0;
    int h, n;

    hant_timing u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .hop_sync_i(hop_sync),
        .rx_multi_dwell_i(rx_multi_dwell_i), .rx_last_bit_i(rx_last_bit_i),
        .rx_final_flag_i(rx_final_flag_i), .tx_start_o(tx_start_o),
        .ack_multi_dwell_o(ack_multi_dwell_o), .fec_en_o(fec_en_o),
        .disp_en_o(disp_en_o));
    hant_radio_model u_radio (.core_clk_i(core_clk_i), .en_i(radio_en),
        .period_i(radio_period), .hop_sync_o(hop_sync));

    // ------------------------------------------------------
    // Clock, hop counting and hang guard
    // ------------------------------------------------------
    initial forever #25 core_clk_i = ~core_clk_i;
    always @(posedge hop_sync) hops++;
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        d = reg_rdata_o;
    endtask : rd
    // Bounded wait; the start pulse stands a whole cycle
    task wait_tx();
        n = 0;
        while (tx_start_o !== 1'b1 && n < 500) begin
            @(negedge core_clk_i);
            n++;
        end
    endtask : wait_tx

    // ------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------
    task test_config();
        rd(hant_pkg::ADDR_HOP_PERIOD, v);
        chk("hop_period", 32'h0000_4E20, v);
        rd(4'hF, v);
        chk("unmapped", 32'h0, v);
        rd(hant_pkg::ADDR_SLOT, v);
        chk("slot_rst", 32'h0000_0100, v);
        chk("ack_rst", 32'h1, {31'h0, ack_multi_dwell_o});
        wr(hant_pkg::ADDR_CTRL, 32'h0000_0006);
        wr(hant_pkg::ADDR_LONG_DWELL, 32'h0000_0001);
        repeat (2) @(negedge core_clk_i);
        chk("fec_disp", 32'h3, {30'h0, disp_en_o, fec_en_o});
        chk("ack_unknown", 32'h1, {31'h0, ack_multi_dwell_o});
        wr(hant_pkg::ADDR_CTRL, 32'h0000_0001);
        rd(hant_pkg::ADDR_HOLD_S, v);
        chk("hold_single", 32'h0000_0400, v);
        rd(hant_pkg::ADDR_STATUS, v);
        chk("long_ok", 32'h1, {30'h0, v[1:0]});
        wr(hant_pkg::ADDR_LONG_DWELL, 32'h0);
        rd(hant_pkg::ADDR_HOLD_S, v);
        chk("hold_multi", 32'h0000_0C00, v);
        $display("config test done");
    endtask : test_config

    task test_tx_hop();
        wr(hant_pkg::ADDR_HOP_PERIOD, 32'h0000_0028);
        radio_period <= 16'h0028;
        radio_en <= 1'b1;
        repeat (100) @(posedge core_clk_i);
        rd(hant_pkg::ADDR_STATUS, v);
        chk("hop_seen", 32'h1, {31'h0, v[3]});
        h = hops;
        wr(hant_pkg::ADDR_CTRL, 32'h0000_0009);
        wait_tx();
        chk("tx_start", 32'h1, {31'h0, tx_start_o});
        chk("tx_hops", 32'h2, 32'(hops - h));
        $display("hop transmit test done");
    endtask : test_tx_hop

    // No hop timing: the slot span paces the start
    task test_tx_blind();
        @(posedge core_clk_i);
        radio_en <= 1'b0;
        wr(hant_pkg::ADDR_SLOT, 32'h0000_0008);
        wr(hant_pkg::ADDR_CTRL, 32'h0000_0008);
        wait_tx();
        chk("blind_wait", 32'h1, {31'h0, n <= 24});
        $display("blind transmit test done");
    endtask : test_tx_blind

    task test_stamp();
        rd(hant_pkg::ADDR_TIME, t0);
        @(posedge core_clk_i);
        rx_last_bit_i <= 1'b1;
        rx_multi_dwell_i <= 1'b1;
        @(posedge core_clk_i);
        rx_last_bit_i <= 1'b0;
        rx_multi_dwell_i <= 1'b0;
        reg_addr_i <= hant_pkg::ADDR_STATUS;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        chk("md_flags", 32'h3, {30'h0, reg_rdata_o[5:4]});
        rd(hant_pkg::ADDR_LAST_BIT_TS, v);
        chk("last_ts", t0 + 32'h2, v);
        rd(hant_pkg::ADDR_STATUS, v);
        chk("ts_new_clr", 32'h0, {31'h0, v[5]});
        rd(hant_pkg::ADDR_TIME, t0);
        @(posedge core_clk_i);
        rx_final_flag_i <= 1'b1;
        @(posedge core_clk_i);
        rx_final_flag_i <= 1'b0;
        rd(hant_pkg::ADDR_FLAG_TS, v);
        chk("flag_ts", t0 + 32'h2, v);
        $display("timestamp test done");
    endtask : test_stamp

    task wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        {reset_n_i, reg_wr_i, reg_rd_i, radio_en} = 4'h0;
        {rx_multi_dwell_i, rx_last_bit_i, rx_final_flag_i} = 3'h0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 32'h0;
        radio_period = 16'h0028;
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        test_config();
        test_tx_hop();
        test_tx_blind();
        test_stamp();
        wrap_up();
    end
endmodule : test_hant_timing
